// *** core/ip_tos_prio_pkg.sv ***
package ip_tos_prio_pkg;

	localparam int PRIO_W      = 2;
	localparam int IDX_W       = 6;
	localparam int IDX_LSB     = 2;
	localparam int ENT_PER_REG = 4;
	localparam int NUM_REGS    = 9;
	localparam int NUM_ENT     = NUM_REGS * ENT_PER_REG;

	localparam logic [7:0] OFF_IDX00_03 = 8'h90;
	localparam logic [7:0] OFF_IDX04_07 = 8'h91;
	localparam logic [7:0] OFF_IDX08_0B = 8'h92;
	localparam logic [7:0] OFF_IDX0C_0F = 8'h93;
	localparam logic [7:0] OFF_IDX10_13 = 8'h94;
	localparam logic [7:0] OFF_IDX14_17 = 8'h95;
	localparam logic [7:0] OFF_IDX18_1B = 8'h96;
	localparam logic [7:0] OFF_IDX1C_1F = 8'h97;
	localparam logic [7:0] OFF_IDX20_23 = 8'h98;

	localparam logic [7:0]        REG_RESET  = 8'h00;
	localparam logic [7:0]        RDATA_NONE = 8'h00;
	localparam logic [PRIO_W-1:0] PRIO_RESET = 2'h0;

	typedef logic [7:0] byte_t;

	typedef struct packed {
		logic  wr;
		logic  rd;
		byte_t addr;
		byte_t wdata;
	} reg_req_s;

	typedef struct packed {
		logic  valid;
		logic  is_ip;
		byte_t tos;
	} cls_req_s;

	typedef struct packed {
		logic              valid;
		logic              hit;
		logic [PRIO_W-1:0] prio;
	} cls_res_s;

endpackage

// *** core/ip_tos_priority_map.sv ***
// Operation
// - tos bits 7:2 index the priority table
// - index zero uses bits 1:0, first register
// - index one uses bits 3:2, first register
// - offset 0x91 holds indices 4 to 7
// - next registers hold next four, low first
// - 0x1F and 0x23 use bits 7:6
// - entries read/write, reset to 00
`timescale 1ns/10ps

module ip_tos_priority_map
(
	input  wire logic                    clock,
	input  wire logic                    nrst,
	input  wire logic                    ce,
	input  wire ip_tos_prio_pkg::reg_req_s reg_req,
	output      ip_tos_prio_pkg::byte_t  reg_rdata,
	output      logic                    reg_rvalid,
	input  wire ip_tos_prio_pkg::cls_req_s cls_req,
	output      ip_tos_prio_pkg::cls_res_s cls_res
);
	import ip_tos_prio_pkg::*;

	// {hit, register index}
	function automatic logic [4:0] reg_decode(input byte_t a);
		logic [4:0] r;
		r = 5'h00;
		case (a)
			OFF_IDX00_03: r = 5'h10;
			OFF_IDX04_07: r = 5'h11;
			OFF_IDX08_0B: r = 5'h12;
			OFF_IDX0C_0F: r = 5'h13;
			OFF_IDX10_13: r = 5'h14;
			OFF_IDX14_17: r = 5'h15;
			OFF_IDX18_1B: r = 5'h16;
			OFF_IDX1C_1F: r = 5'h17;
			OFF_IDX20_23: r = 5'h18;
			default:      r = 5'h00;
		endcase
		return r;
	endfunction

	byte_t             map_reg [NUM_REGS];
	logic [4:0]        dec;
	logic [IDX_W-1:0]  idx;
	logic              in_range;
	logic [PRIO_W-1:0] entry;

	assign dec      = reg_decode(reg_req.addr);
	assign idx      = cls_req.tos[7:IDX_LSB];
	assign in_range = ({1'b0, idx} < 7'(NUM_ENT));
	assign entry    = in_range ? 2'(map_reg[idx[5:2]] >> {idx[1:0], 1'b0}) : PRIO_RESET;

	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++)
		begin : g_map
			always_ff @(posedge clock)
			begin
				if (!nrst)
					map_reg[g] <= REG_RESET;
				else if (ce && reg_req.wr && dec[4] && (dec[3:0] == 4'(g)))
					map_reg[g] <= reg_req.wdata;
			end
		end
	endgenerate

	// register read port, one cycle latency
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			reg_rvalid <= 1'b0;
			reg_rdata  <= RDATA_NONE;
		end
		else if (ce)
		begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd)
				reg_rdata <= dec[4] ? map_reg[dec[3:0]] : RDATA_NONE;
		end
	end

	// classification lookup, one cycle latency
	always_ff @(posedge clock)
	begin
		if (!nrst)
			cls_res <= '0;
		else if (ce)
		begin
			cls_res.valid <= cls_req.valid;
			cls_res.hit   <= cls_req.valid && cls_req.is_ip && in_range;
			cls_res.prio  <= (cls_req.valid && cls_req.is_ip) ? entry : PRIO_RESET;
		end
	end

	// checking helpers
	logic [NUM_REGS*8-1:0] flat;
	logic [PRIO_W-1:0]     exp_prio;
	logic                  ip_look;

	generate
		for (g = 0; g < NUM_REGS; g++)
		begin : g_flat
			assign flat[g*8 +: 8] = map_reg[g];
		end
	endgenerate

	assign exp_prio = flat[{idx, 1'b0} +: PRIO_W];
	assign ip_look  = ce && cls_req.valid && cls_req.is_ip;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	property p_index_lookup;
		ip_look && in_range |=> cls_res.hit && (cls_res.prio == $past(exp_prio));
	endproperty
	a_index_lookup: assert property (p_index_lookup) else $error("table lookup wrong");

	property p_idx00;
		ip_look && (idx == 6'h00) |=> cls_res.prio == $past(map_reg[0][1:0]);
	endproperty
	a_idx00: assert property (p_idx00) else $error("index 0 wrong field");

	property p_idx01;
		ip_look && (idx == 6'h01) |=> cls_res.prio == $past(map_reg[0][3:2]);
	endproperty
	a_idx01: assert property (p_idx01) else $error("index 1 wrong field");

	property p_reg91;
		ce && reg_req.wr && (reg_req.addr == OFF_IDX04_07)
		##1 ip_look && !reg_req.wr && (idx == 6'h07)
		|=> cls_res.prio == $past(reg_req.wdata[7:6], 2);
	endproperty
	a_reg91: assert property (p_reg91) else $error("index 7 not from 0x91");

	property p_reg94;
		ce && reg_req.wr && (reg_req.addr == OFF_IDX10_13)
		##1 ip_look && !reg_req.wr && (idx == 6'h10)
		|=> cls_res.prio == $past(reg_req.wdata[1:0], 2);
	endproperty
	a_reg94: assert property (p_reg94) else $error("index 0x10 not from 0x94");

	property p_idx1f;
		ip_look && (idx == 6'h1F) |=> cls_res.prio == $past(map_reg[7][7:6]);
	endproperty
	a_idx1f: assert property (p_idx1f) else $error("index 0x1F wrong field");

	property p_idx23;
		ip_look && (idx == 6'h23) |=> cls_res.prio == $past(map_reg[8][7:6]);
	endproperty
	a_idx23: assert property (p_idx23) else $error("index 0x23 wrong field");

	property p_reset_clear;
		@(posedge clock) disable iff (1'b0)
		!nrst |=> (flat == '0) && !cls_res.valid && !reg_rvalid;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset not cleared");

	property p_readback;
		ce && reg_req.wr && dec[4]
		##1 ce && !reg_req.wr && reg_req.rd && (reg_req.addr == $past(reg_req.addr))
		|=> reg_rvalid && (reg_rdata == $past(reg_req.wdata, 2));
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	property p_non_ip;
		ce && cls_req.valid && !cls_req.is_ip |=> cls_res.valid && !cls_res.hit
			&& (cls_res.prio == PRIO_RESET);
	endproperty
	a_non_ip: assert property (p_non_ip) else $error("non-IP frame used table");

	// out-of-range and idle requests never hit
	property p_out_range;
		ip_look && !in_range |=> cls_res.valid && !cls_res.hit
			&& (cls_res.prio == PRIO_RESET);
	endproperty
	a_out_range: assert property (p_out_range) else $error("index beyond table hit");

	property p_no_request;
		ce && !cls_req.valid |=> !cls_res.valid && !cls_res.hit;
	endproperty
	a_no_request: assert property (p_no_request) else $error("result without request");

	property p_idx04;
		ip_look && (idx == 6'h04) |=> cls_res.prio == $past(map_reg[1][1:0]);
	endproperty
	a_idx04: assert property (p_idx04) else $error("index 4 wrong field");

	// unmapped offsets: reads answer zero, writes leave table alone
	property p_unmapped_read;
		ce && reg_req.rd && !dec[4]
		|=> reg_rvalid && (reg_rdata == RDATA_NONE);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

	property p_unmapped_write;
		ce && reg_req.wr && !dec[4] |=> $stable(flat);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("bad write");

	property p_rvalid_pulse;
		ce && !reg_req.rd |=> !reg_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("stray read answer");

	// ce low freezes table and every output
	property p_ce_hold;
		!ce |=> $stable(flat) && $stable(cls_res) && $stable(reg_rvalid)
			&& $stable(reg_rdata);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved with ce low");

	c_hit: cover property (ip_look && in_range ##1 cls_res.hit && (cls_res.prio != PRIO_RESET));
	c_non_ip: cover property (ce && cls_req.valid && !cls_req.is_ip);
	c_out_range: cover property (ip_look && !in_range);
	c_wr_rd: cover property (ce && reg_req.wr && dec[4] ##1 ce && reg_req.rd ##1 reg_rvalid);
	c_frozen: cover property (!ce && reg_req.wr ##1 ce);

endmodule // ip_tos_priority_map

// *** tb/ip_tos_priority_map_bench.sv ***
`timescale 1ns/10ps

module ip_tos_priority_map_bench;
	import ip_tos_prio_pkg::*;

	logic        clock           = 1'b0;
	logic        nrst            = 1'b0;
	logic        ce              = 1'b1;
	reg_req_s    req             = '0;
	cls_req_s    creq            = '0;
	byte_t       rdata;
	logic        rvalid;
	cls_res_s    cres;
	byte_t       mdl [NUM_REGS]  = '{default: 8'h00};
	byte_t       rd_q [$];
	logic [2:0]  cl_q [$];
	logic [31:0] seed            = 32'h45EF;
	int          err_total       = 0;
	int          samples_checked = 0;

	ip_tos_priority_map dut (.clock(clock), .nrst(nrst), .ce(ce), .reg_req(req),
		.reg_rdata(rdata), .reg_rvalid(rvalid), .cls_req(creq), .cls_res(cres));

	initial forever #4 clock = ~clock;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cmp(logic [7:0] got, logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one strobe per call, back to back; model updated as the write is issued
	task automatic reg_op(logic w, byte_t a, byte_t d);
		@(negedge clock);
		creq = '0;
		req = '{w, !w, a, d};
		if (w && a <= OFF_IDX20_23)
			mdl[a - OFF_IDX00_03] = d;
		if (!w)
			rd_q.push_back((a <= OFF_IDX20_23) ? mdl[a - OFF_IDX00_03] : RDATA_NONE);
	endtask

	task automatic lk(logic ip, byte_t t);
		logic hit;
		@(negedge clock);
		req = '0;
		creq = '{1'b1, ip, t};
		hit = ip && (t[7:2] < NUM_ENT);
		cl_q.push_back({hit, hit ? mdl[t[7:4]][{t[3:2], 1'b0} +: 2] : PRIO_RESET});
	endtask

	// every index, IP and non-IP, random low tos bits
	task automatic sweep();
		logic [31:0] r;
		for (int i = 0; i < 64; i++)
		begin
			r = xs();
			lk(1'b1, {i[5:0], r[1:0]});
			lk(1'b0, {i[5:0], r[3:2]});
		end
	endtask

	// idle both ports and wait for every noted result
	task automatic drain();
		@(negedge clock);
		req = '0;
		creq = '0;
		for (int i = 0; i < 8 && (rd_q.size() || cl_q.size()); i++)
			@(negedge clock);
		if (rd_q.size() || cl_q.size())
		begin
			err_total++;
			tally_and_finish();
		end
	endtask

	// write and lookup offered with ce low must leave no trace
	task automatic frozen_op(byte_t d);
		@(negedge clock);
		ce = 1'b0;
		req = '{1'b1, 1'b0, OFF_IDX00_03, d};
		creq = '{1'b1, 1'b1, 8'h00};
		@(negedge clock);
		ce = 1'b1;
		req = '0;
		creq = '0;
	endtask

	always @(negedge clock)
		if (nrst)
		begin
			if (rvalid === 1'b1)
				cmp(rdata, rd_q.size() ? rd_q.pop_front() : 8'hXX);
			if (cres.valid === 1'b1)
				cmp({5'h00, cres.hit, cres.prio}, cl_q.size() ? {5'h00, cl_q.pop_front()} : 8'hXX);
		end

	initial
	begin
		logic [31:0] rnd;
		repeat (8) @(negedge clock);
		nrst = 1'b1;
		for (int i = 0; i < 10; i++)
			reg_op(1'b0, OFF_IDX00_03 + i[7:0], 8'h00);
		sweep();
		for (int i = 0; i < 10; i++)
		begin
			rnd = xs();
			reg_op(1'b1, OFF_IDX00_03 + i[7:0], rnd[7:0]);
			reg_op(1'b0, OFF_IDX00_03 + i[7:0], 8'h00);
		end
		rnd = xs();
		reg_op(1'b1, OFF_IDX04_07, rnd[7:0]);
		lk(1'b1, {6'h07, rnd[9:8]});
		reg_op(1'b1, OFF_IDX10_13, rnd[23:16]);
		lk(1'b1, {6'h10, rnd[25:24]});
		sweep();
		drain();
		frozen_op(~mdl[0]);
		reg_op(1'b0, OFF_IDX00_03, 8'h00);
		drain();
		nrst = 1'b0;
		mdl = '{default: 8'h00};
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		for (int i = 0; i < 10; i++)
			reg_op(1'b0, OFF_IDX00_03 + i[7:0], 8'h00);
		drain();
		tally_and_finish();
	end
endmodule // ip_tos_priority_map_bench
